// ===== src/irs_top.sv
// Contract
// (RULE1) reset pin low or selected keys low together puts the device in reset
// (RULE2) on release the cpu fetches its start vector from bank 0 address zero
// (RULE3) outside party holds the reset pin low long enough after power on
// (RULE4) first reset after power on comes from the reset pin, not the keys
// (RULE5) keys must stay low together two seconds before reset is taken
// (RULE6) in sleep or oscillator wait the key timer is bypassed, reset is immediate
// (RULE7) key group is a mask choice: none, two, three or four keys
// (RULE8) system never holds the selected keys low together in normal use
// (RULE9) after pin release cpu waits 8192 slow oscillator periods
// (RULE10) sleep key reset starts cpu after key release plus oscillator wait
// (RULE11) qualified key reset outside sleep gives a 64 period internal pulse
// (RULE12) reset clears arithmetic flags, sets interrupt flags, bank one, pages zero
// (RULE13) vector load also copies new code bank value into code bank
// (RULE14) reset leaves data and display ram untouched
// (RULE15) stack lives in page 0, pointer undefined until software loads it
// (RULE16) bus mode resets to single chip, or mask choice in external program mode
// (RULE17) shared terminals default to port functions after reset; external program mode with nonzero EXT_BUS_OPTION enables all select outputs
// (RULE18) all interrupts masked until both system bytes are written
// (RULE19) bus mode field bits 7:6 decode, resetting to 00 in internal rom mode
// (RULE20) block size field bits 5:4 resets to 11, used in 64K mode only
// (RULE21) bits 2:0 enable select outputs, forced off in single chip; bit 3 reads 0
// (RULE22) reset pin and keys are synchronised to the slow clock first
`include "irs_cfg.svh"

module irs_top #(
    parameter int unsigned QUAL_TICKS      = `IRS_QUAL_TICKS,
    parameter int unsigned STAB_TICKS      = `IRS_STAB_TICKS,
    parameter int unsigned PULSE_TICKS     = `IRS_PULSE_TICKS,
    parameter logic [1:0]  KEY_GROUP       = 2'h3,
    parameter logic        EXT_PROG_MODE   = 1'b0,
    parameter logic [1:0]  EXT_BUS_OPTION  = 2'h1
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   reset_pin_n,
    input  wire logic [3:0]             key_reset_inputs,
    input  wire logic                   sleep_mode,
    input  wire logic [`IRS_ADDR_W-1:0] io_addr,
    input  wire logic                   io_wr,
    input  wire logic                   io_rd,
    input  wire logic [7:0]             io_wdata,
    output logic      [7:0]             io_rdata,
    output logic                        cpu_reset_n,
    output logic                        vector_fetch,
    output logic      [`IRS_ADDR_W-1:0] vector_addr,
    output logic                        code_bank_load,
    output logic      [39:0]            core_init,
    output logic                        int_mask,
    output logic      [1:0]             bus_mode,
    output logic      [1:0]             block_size,
    output logic      [2:0]             select_en
);
    logic [`IRS_TICK_W-1:0] div_ff;
    logic [`IRS_TICK_W-1:0] nxt_div;
    logic                   tick_ff;
    logic                   nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_div  = div_ff + `IRS_TICK_W'(1);
        if (div_ff == `IRS_TICK_W'(`IRS_TICK_DIV - 1)) begin
            nxt_div  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    logic       pin_s;
    logic [3:0] key_s;
    logic       keys_low;

    // pin reads as asserted until sampled, so power-on always passes the pin path
    irs_sync #(.W(1), .RST_VAL(1'b0)) u_pin_sync (
        .clk  (clk),
        .nrst (nrst),
        .en   (tick_ff),
        .d    (reset_pin_n),
        .q    (pin_s)
    );

    irs_sync #(.W(4), .RST_VAL(4'hf)) u_key_sync (
        .clk  (clk),
        .nrst (nrst),
        .en   (tick_ff),
        .d    (key_reset_inputs),
        .q    (key_s)
    );

    localparam logic [3:0] KEY_MASK = (KEY_GROUP == 2'h1) ? 4'h3
                                    : (KEY_GROUP == 2'h2) ? 4'h7
                                    : (KEY_GROUP == 2'h3) ? 4'hf : 4'h0;
    assign keys_low = (KEY_MASK != 4'h0) && ((key_s & KEY_MASK) == 4'h0); // RULE7

    irs_pkg::irs_state_e state_ff;
    irs_pkg::irs_state_e nxt_state;
    irs_qual_if qif ();

    assign qif.tick     = tick_ff;
    assign qif.keys_low = keys_low;
    assign qif.qual_ok  = (state_ff == irs_pkg::IRS_ST_RUN) && !sleep_mode; // RULE6

    irs_qual #(.QUAL_TICKS(QUAL_TICKS)) u_qual (
        .clk  (clk),
        .nrst (nrst),
        .qi   (qif.qual)
    );

    logic [`IRS_CNT_W-1:0] cnt_ff;
    logic [`IRS_CNT_W-1:0] nxt_cnt;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        if (!pin_s) begin
            nxt_state = irs_pkg::IRS_ST_PIN; // RULE1
            nxt_cnt   = '0;
        end else begin
            case (state_ff)
                irs_pkg::IRS_ST_PIN: begin
                    nxt_state = irs_pkg::IRS_ST_STAB; // RULE9
                    nxt_cnt   = '0;
                end
                irs_pkg::IRS_ST_STAB: begin
                    if (keys_low) begin
                        nxt_state = irs_pkg::IRS_ST_KEY; // RULE6
                        nxt_cnt   = '0;
                    end else if (tick_ff) begin
                        if (cnt_ff == `IRS_CNT_W'(STAB_TICKS - 1)) begin // RULE9
                            nxt_state = irs_pkg::IRS_ST_RUN;
                            nxt_cnt   = '0;
                        end else begin
                            nxt_cnt = cnt_ff + `IRS_CNT_W'(1);
                        end
                    end
                end
                irs_pkg::IRS_ST_KEY: begin
                    if (!keys_low) begin
                        nxt_state = irs_pkg::IRS_ST_STAB; // RULE10
                        nxt_cnt   = '0;
                    end
                end
                irs_pkg::IRS_ST_PULSE: begin
                    // cpu restarts after the pulse even with keys still low
                    if (tick_ff) begin
                        if (cnt_ff == `IRS_CNT_W'(PULSE_TICKS - 1)) begin // RULE11
                            nxt_state = irs_pkg::IRS_ST_RUN;
                            nxt_cnt   = '0;
                        end else begin
                            nxt_cnt = cnt_ff + `IRS_CNT_W'(1);
                        end
                    end
                end
                irs_pkg::IRS_ST_RUN: begin
                    if (sleep_mode && keys_low) begin
                        nxt_state = irs_pkg::IRS_ST_KEY; // RULE6
                    end else if (qif.fire) begin
                        nxt_state = irs_pkg::IRS_ST_PULSE; // RULE11
                        nxt_cnt   = '0;
                    end
                end
                default: begin
                    nxt_state = irs_pkg::IRS_ST_PIN;
                    nxt_cnt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= irs_pkg::IRS_ST_PIN;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    logic                   run_nxt;
    logic                   cfg_wr;
    logic                   cpu_rst_n_ff;
    logic                   nxt_cpu_rst_n;
    logic                   start_ff;
    logic                   nxt_start;
    logic                   seen0_ff;
    logic                   nxt_seen0;
    logic                   seen1_ff;
    logic                   nxt_seen1;
    logic                   int_mask_ff;
    logic                   nxt_int_mask;
    logic [1:0]             bus_fld_ff;
    logic [1:0]             nxt_bus_fld;
    logic [1:0]             size_ff;
    logic [1:0]             nxt_size;
    logic [2:0]             sel_ff;
    logic [2:0]             nxt_sel;
    logic [1:0]             bus_eff;
    logic [1:0]             bus_mode_ff;
    logic [2:0]             sel_en_ff;
    logic [2:0]             nxt_sel_en;
    logic [7:0]             rdata_ff;
    logic [7:0]             nxt_rdata;
    logic [39:0]            init_ff;
    logic [`IRS_ADDR_W-1:0] vec_ff;
    localparam logic [1:0]  BUS_RST = EXT_PROG_MODE ? EXT_BUS_OPTION : `IRS_BUS_RST;

    assign run_nxt = (nxt_state == irs_pkg::IRS_ST_RUN);
    // writes from a cpu still held in reset are dropped
    assign cfg_wr  = io_wr && (state_ff == irs_pkg::IRS_ST_RUN);

    always_comb begin
        nxt_cpu_rst_n = run_nxt;
        nxt_start     = run_nxt && (state_ff != irs_pkg::IRS_ST_RUN); // RULE2 RULE13
        nxt_seen0     = seen0_ff;
        nxt_seen1     = seen1_ff;
        nxt_bus_fld   = bus_fld_ff;
        nxt_size      = size_ff;
        nxt_sel       = sel_ff;
        if (!run_nxt) begin
            nxt_seen0   = 1'b0; // RULE18
            nxt_seen1   = 1'b0;
            nxt_bus_fld = BUS_RST; // RULE16 RULE19
            nxt_size    = `IRS_SIZE_RST; // RULE20
            nxt_sel     = `IRS_SEL_RST; // RULE21
        end else if (cfg_wr && io_addr == `IRS_CFG_ADDR) begin
            nxt_seen0   = 1'b1;
            nxt_bus_fld = io_wdata[`IRS_BUS_HI:`IRS_BUS_LO];
            nxt_size    = io_wdata[`IRS_SIZE_HI:`IRS_SIZE_LO];
            nxt_sel     = io_wdata[`IRS_SEL_HI:0];
        end else if (cfg_wr && io_addr == `IRS_SYS1_ADDR) begin
            nxt_seen1 = 1'b1;
        end
        nxt_int_mask = !(nxt_seen0 && nxt_seen1); // RULE18
        // code 00 in external program mode means the mask-chosen mode
        bus_eff = (nxt_bus_fld == irs_pkg::IRS_BUS_SINGLE && EXT_PROG_MODE)
                  ? EXT_BUS_OPTION : nxt_bus_fld; // RULE16 RULE19
        // single chip keeps the select pins as plain ports
        nxt_sel_en = (bus_eff == irs_pkg::IRS_BUS_SINGLE) ? 3'h0 : nxt_sel; // RULE17 RULE21
        nxt_rdata = 8'h00;
        if (io_rd && io_addr == `IRS_CFG_ADDR) begin
            nxt_rdata = {bus_fld_ff, size_ff, 1'b0, sel_ff}; // RULE21
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_rst_n_ff <= 1'b0;
            start_ff     <= 1'b0;
            seen0_ff     <= 1'b0;
            seen1_ff     <= 1'b0;
            int_mask_ff  <= 1'b1;
            bus_fld_ff   <= BUS_RST;
            size_ff      <= `IRS_SIZE_RST;
            sel_ff       <= `IRS_SEL_RST;
            bus_mode_ff  <= BUS_RST;
            sel_en_ff    <= 3'h0;
            rdata_ff     <= 8'h00;
            init_ff      <= {`IRS_FLAGS_INIT, `IRS_NB_INIT,
                             `IRS_PAGE_INIT, `IRS_PAGE_INIT, `IRS_PAGE_INIT}; // RULE12
            vec_ff       <= `IRS_VECTOR_ADDR; // RULE2
        end else begin
            cpu_rst_n_ff <= nxt_cpu_rst_n;
            start_ff     <= nxt_start;
            seen0_ff     <= nxt_seen0;
            seen1_ff     <= nxt_seen1;
            int_mask_ff  <= nxt_int_mask;
            bus_fld_ff   <= nxt_bus_fld;
            size_ff      <= nxt_size;
            sel_ff       <= nxt_sel;
            bus_mode_ff  <= bus_eff;
            sel_en_ff    <= nxt_sel_en;
            rdata_ff     <= nxt_rdata;
            init_ff      <= init_ff;
            vec_ff       <= vec_ff;
        end
    end

    // no ram clear and no stack pointer value here: software owns both (RULE14, RULE15)
    assign io_rdata       = rdata_ff;
    assign cpu_reset_n    = cpu_rst_n_ff;
    assign vector_fetch   = start_ff;
    assign code_bank_load = start_ff;
    assign vector_addr    = vec_ff;
    assign core_init      = init_ff;
    assign int_mask       = int_mask_ff;
    assign bus_mode       = bus_mode_ff;
    assign block_size     = size_ff;
    assign select_en      = sel_en_ff;

    pin_holds_a: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        !pin_s |=> !cpu_rst_n_ff ##1 !cpu_rst_n_ff)
        else $error("cpu left reset while reset pin low");
    start_pulse_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
        $rose(cpu_rst_n_ff) |-> start_ff ##1 !start_ff)
        else $error("start vector fetch not a single pulse at release");
    release_path_a: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        $rose(cpu_rst_n_ff) |-> ($past(state_ff) == irs_pkg::IRS_ST_STAB
            && $past(cnt_ff) == `IRS_CNT_W'(STAB_TICKS - 1))
            || ($past(state_ff) == irs_pkg::IRS_ST_PULSE
            && $past(cnt_ff) == `IRS_CNT_W'(PULSE_TICKS - 1)))
        else $error("cpu released without full wait or pulse");
    pulse_entry_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        (state_ff == irs_pkg::IRS_ST_RUN && qif.fire && pin_s && !sleep_mode)
            |=> state_ff == irs_pkg::IRS_ST_PULSE && !cpu_rst_n_ff)
        else $error("qualified key reset gave no internal pulse");
    sleep_bypass_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        (state_ff == irs_pkg::IRS_ST_RUN && sleep_mode && keys_low && pin_s)
            |=> state_ff == irs_pkg::IRS_ST_KEY ##1 !cpu_rst_n_ff)
        else $error("sleep key reset not immediate");
    key_release_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        (state_ff == irs_pkg::IRS_ST_KEY && !keys_low && pin_s)
            |=> state_ff == irs_pkg::IRS_ST_STAB && cnt_ff == '0)
        else $error("key release did not start oscillator wait");
    irq_mask_a: assert property (@(posedge clk) disable iff (!nrst) // RULE18
        $fell(int_mask_ff) |-> $past(io_wr) && cpu_rst_n_ff
            && ($past(io_addr) == `IRS_CFG_ADDR || $past(io_addr) == `IRS_SYS1_ADDR))
        else $error("interrupt mask dropped without system write");
    cfg_reset_a: assert property (@(posedge clk) disable iff (!nrst) // RULE20
        !cpu_rst_n_ff |-> size_ff == `IRS_SIZE_RST && sel_ff == `IRS_SEL_RST
            && int_mask_ff)
        else $error("configuration not at reset value during reset");
    single_ports_a: assert property (@(posedge clk) disable iff (!nrst) // RULE21
        bus_mode_ff == irs_pkg::IRS_BUS_SINGLE |-> sel_en_ff == 3'h0
            && io_rdata[3] == 1'b0)
        else $error("select outputs enabled in single chip mode");
endmodule

// ===== inc/irs_cfg.svh
`ifndef IRS_CFG_SVH
`define IRS_CFG_SVH

// system clock and slow oscillator
`define IRS_CLK_HZ        100000000
`define IRS_SLOW_HZ       32768
// slow tick period in system cycles, rounded to nearest
`define IRS_TICK_DIV      ((`IRS_CLK_HZ + (`IRS_SLOW_HZ / 2)) / `IRS_SLOW_HZ)
`define IRS_TICK_W        12

// times counted in slow ticks
`define IRS_QUAL_TIME_S   2
`define IRS_QUAL_TICKS    (`IRS_QUAL_TIME_S * `IRS_SLOW_HZ)
`define IRS_STAB_TICKS    8192
`define IRS_PULSE_TICKS   64
`define IRS_CNT_W         17

// register map
`define IRS_ADDR_W        24
`define IRS_CFG_ADDR      24'hff00
`define IRS_SYS1_ADDR     24'hff01
`define IRS_BUS_HI        7
`define IRS_BUS_LO        6
`define IRS_SIZE_HI       5
`define IRS_SIZE_LO       4
`define IRS_SEL_HI        2
`define IRS_BUS_RST       2'h0
`define IRS_SIZE_RST      2'h3
`define IRS_SEL_RST       3'h7

// cpu reset values
`define IRS_VECTOR_ADDR   24'h000000
`define IRS_FLAGS_INIT    8'hc0
`define IRS_NB_INIT       8'h01
`define IRS_PAGE_INIT     8'h00

`endif

// ===== inc/irs_pkg.sv
package irs_pkg;

    typedef enum {
        IRS_ST_PIN,
        IRS_ST_STAB,
        IRS_ST_KEY,
        IRS_ST_PULSE,
        IRS_ST_RUN
    } irs_state_e;

    typedef enum logic [1:0] {
        IRS_BUS_SINGLE = 2'h0,
        IRS_BUS_64K    = 2'h1,
        IRS_BUS_4MMIN  = 2'h2,
        IRS_BUS_4MMAX  = 2'h3
    } irs_bus_e;

endpackage

// ===== inc/irs_qual_if.sv
interface irs_qual_if;
    logic tick;
    logic keys_low;
    logic qual_ok;
    logic fire;

    modport qual (
        input  tick,
        input  keys_low,
        input  qual_ok,
        output fire
    );

    modport ctl (
        output tick,
        output keys_low,
        output qual_ok,
        input  fire
    );
endinterface

// ===== src/irs_sync.sv
module irs_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // sampled on the slow tick so short glitches never reach the sequencer
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i]; // RULE22
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            q_ff  <= RST_VAL;
        end else if (en) begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule

// ===== src/irs_qual.sv
`include "irs_cfg.svh"

module irs_qual #(
    parameter int unsigned QUAL_TICKS = `IRS_QUAL_TICKS
) (
    input  wire logic clk,
    input  wire logic nrst,
    irs_qual_if.qual  qi
);
    logic [`IRS_CNT_W-1:0] cnt_ff;
    logic [`IRS_CNT_W-1:0] nxt_cnt;
    logic                  armed_ff;
    logic                  nxt_armed;
    logic                  fire_ff;
    logic                  nxt_fire;

    // one reset per low episode: keys held low after the pulse must not retrigger
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_armed = armed_ff;
        nxt_fire  = 1'b0;
        if (!qi.keys_low) begin
            nxt_cnt   = '0;
            nxt_armed = 1'b1;
        end else if (!qi.qual_ok) begin
            nxt_cnt = '0; // RULE6
        end else if (armed_ff && qi.tick) begin
            if (cnt_ff == `IRS_CNT_W'(QUAL_TICKS - 1)) begin // RULE5
                nxt_fire  = 1'b1;
                nxt_armed = 1'b0;
                nxt_cnt   = '0;
            end else begin
                nxt_cnt = cnt_ff + `IRS_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff   <= '0;
            armed_ff <= 1'b0;
            fire_ff  <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            armed_ff <= nxt_armed;
            fire_ff  <= nxt_fire;
        end
    end

    assign qi.fire = fire_ff;

    qual_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        fire_ff |-> $past(qi.keys_low) && $past(qi.qual_ok) && $past(qi.tick))
        else $error("key reset qualified without a full low hold");
endmodule

// ===== verification/irs_ext_model.sv
module irs_ext_model #(
    parameter int unsigned MIN_HOLD = 8
) (
    input  wire logic       clk,
    input  wire logic       hold_pin,
    input  wire logic [3:0] press,
    output logic            reset_pin_n,
    output logic      [3:0] key_reset_inputs
);
    timeunit 1ns;
    timeprecision 1ps;
    // power-on span the pin stays low even if the bench lets go early
    int unsigned pwr_cnt = 0;
    always @(posedge clk) begin
        if (pwr_cnt < MIN_HOLD) begin
            pwr_cnt <= pwr_cnt + 1;
        end
    end
    // pull-up brings a released pin high
    assign reset_pin_n = !(hold_pin || pwr_cnt < MIN_HOLD);
    // pulled-up switches, low only while pressed
    assign key_reset_inputs = ~press;
endmodule

// ===== verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TICK = 3052;
    localparam int unsigned QUAL = 5;
    localparam int unsigned STAB = 2;
    logic        clk = 1'h0;
    logic        nrst = 1'h0;
    logic        hold_pin = 1'h1;
    logic [3:0]  press = 4'h0;
    logic        sleep_mode = 1'h0;
    logic [23:0] io_addr = 24'h0;
    logic        io_wr = 1'h0;
    logic        io_rd = 1'h0;
    logic [7:0]  io_wdata = 8'h0;
    logic        reset_pin_n;
    logic [3:0]  key_reset_inputs;
    logic [7:0]  io_rdata;
    logic        cpu_reset_n;
    logic        vector_fetch;
    logic        code_bank_load;
    logic        int_mask;
    logic [23:0] vector_addr;
    logic [39:0] core_init;
    logic [1:0]  bus_mode;
    logic [1:0]  block_size;
    logic [2:0]  select_en;
    logic [31:0] seed = 32'h0475;
    logic [7:0]  d;
    logic [7:0]  q;
    int          fails = 0;
    int          checked = 0;
    int          n;

    irs_ext_model ext (.clk(clk), .hold_pin(hold_pin), .press(press),
        .reset_pin_n(reset_pin_n), .key_reset_inputs(key_reset_inputs));

    irs_top #(.QUAL_TICKS(QUAL), .STAB_TICKS(STAB), .PULSE_TICKS(2)) dut (
        .clk(clk), .nrst(nrst), .reset_pin_n(reset_pin_n),
        .key_reset_inputs(key_reset_inputs), .sleep_mode(sleep_mode),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .cpu_reset_n(cpu_reset_n),
        .vector_fetch(vector_fetch), .vector_addr(vector_addr),
        .code_bank_load(code_bank_load), .core_init(core_init),
        .int_mask(int_mask), .bus_mode(bus_mode), .block_size(block_size),
        .select_en(select_en));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // select outputs fall back to port output in single chip
    function automatic logic [2:0] exp_sel(input logic [7:0] v);
        return (v[7:6] == 2'h0) ? 3'h0 : v[2:0];
    endfunction

    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_cpu(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (cpu_reset_n !== lvl && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
        if (cpu_reset_n !== lvl) begin
            fails++;
            $display("BAD cpu_reset_n expected %b seen %b", lvl, cpu_reset_n);
            close_out();
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [7:0] v);
        @(negedge clk);
        io_addr = a;
        io_wdata = v;
        io_wr = 1'h1;
        @(negedge clk);
        io_wr = 1'h0;
    endtask

    task automatic rd(input logic [23:0] a, output logic [7:0] v);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'h1;
        @(negedge clk);
        io_rd = 1'h0;
        v = io_rdata;
    endtask

    initial begin
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'h1;
        chk("cpu_reset_n", 0, cpu_reset_n);
        chk("int_mask", 1, int_mask);
        chk("bus_mode", 0, bus_mode);
        // a write while still in reset must not land
        wr(24'hff00, 8'h40);
        hold_pin = 1'h0;
        wait_cpu(1'h1, (STAB + 8) * TICK, n);
        chk("stab_wait", 1, n >= (STAB + 2) * TICK);
        chk("vector_fetch", 1, vector_fetch);
        chk("code_bank_load", 1, code_bank_load);
        chk("vector_addr", 0, vector_addr);
        chk("core_init", 40'hc001000000, core_init);
        chk("bus_mode", 0, bus_mode);
        chk("block_size", 3, block_size);
        chk("select_en", 0, select_en);
        @(negedge clk);
        chk("vector_fetch", 0, vector_fetch);
        rd(24'hff00, q);
        chk("cfg_reset", 8'h37, q);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            d = (i == 0) ? 8'h0f : (i == 1) ? 8'hff : seed[7:0];
            wr(24'hff00, d);
            chk("bus_mode", d[7:6], bus_mode);
            chk("block_size", d[5:4], block_size);
            chk("select_en", exp_sel(d), select_en);
            chk("int_mask", 1, int_mask);
            rd(24'hff00, q);
            chk("cfg_read", d & 8'hf7, q);
        end
        wr(24'hff01, 8'h5a);
        chk("int_mask", 0, int_mask);
        rd(24'hff01, q);
        chk("sys_read", 0, q);
        rd(24'hff02, q);
        chk("unmapped", 0, q);
        // three keys of a four-key group must not reset, even bypassed
        sleep_mode = 1'h1;
        press = 4'h7;
        // wait out the key synchroniser, else a wrong mask could not show
        repeat (5 * TICK) @(negedge clk);
        chk("cpu_reset_n", 1, cpu_reset_n);
        press = 4'hf;
        wait_cpu(1'h0, 5 * TICK, n);
        sleep_mode = 1'h0;
        chk("int_mask", 1, int_mask);
        repeat (2 * TICK) @(negedge clk);
        chk("cpu_reset_n", 0, cpu_reset_n);
        press = 4'h0;
        wait_cpu(1'h1, (STAB + 8) * TICK, n);
        chk("sleep_wait", 1, n >= (STAB + 2) * TICK);
        chk("bus_mode", 0, bus_mode);
        // outside sleep the keys must be qualified first
        press = 4'hf;
        repeat (QUAL * TICK) @(negedge clk);
        chk("cpu_reset_n", 1, cpu_reset_n);
        wait_cpu(1'h0, 6 * TICK, n);
        // keys stay low: the internal pulse must still let the cpu go
        wait_cpu(1'h1, 10 * TICK, n);
        chk("vector_fetch", 1, vector_fetch);
        press = 4'h0;
        close_out();
    end
endmodule
